//--- design/rss_exec.sv
/*
  rss_exec: executes rotate-right-through-link into the working register,
  the three borrow-subtract forms and the two decrement-and-skip forms.
  assumes the sequencer presents one instruction with its memory operand
  already read, on the same clock, and writes mem_wdata when mem_we.
*/
`timescale 1ns/1ps

module rss_exec
  import rss_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // instruction from sequencer
  input wire rss_req_s req,
  output logic req_ready,
  // data memory write-back
  output logic mem_we,
  output logic [7:0] mem_wdata,
  // core state
  output logic [7:0] work,
  output rss_flags_s flags,
  output logic skip,
  output logic done
);

  ////////////////////////////////////////////////////////////////////////
  rss_core_s state_reg;
  rss_core_s state_next;
  logic take;
  logic [8:0] diff;
  logic [4:0] ndiff;
  logic [7:0] sub_b;
  logic borrow_in;
  logic [7:0] dec;
  logic ovf;

  // a skip cycle blocks the next issue
  assign req_ready = (state_reg.st == ST_RUN);
  assign take = req.valid && req_ready;

  // borrow-subtract decode, used only by the checks
  function automatic logic is_borrow_op(input rss_op_e op);
    return (op == OP_SUBB_MEM) || (op == OP_SUBB_IMM) ||
      (op == OP_SUBB_TO_MEM);
  endfunction

  // shared 9-bit borrow subtract; bit 8 set means negative
  assign sub_b = (req.op == OP_SUBB_IMM) ? req.lit : req.mem;
  assign borrow_in = ~state_reg.fl.c;
  assign diff = {1'b0, state_reg.work} - {1'b0, sub_b} - {8'h00, borrow_in};
  assign ndiff = {1'b0, state_reg.work[3:0]} - {1'b0, sub_b[3:0]}
    - {4'h0, borrow_in};
  assign ovf = (state_reg.work[7] != sub_b[7]) &&
    (diff[7] != state_reg.work[7]);
  assign dec = req.mem - RSS_ONE;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    state_next.mem_we = 1'b0;
    state_next.skip = 1'b0;
    state_next.done = 1'b0;
    case (state_reg.st)
      ST_RUN: begin
        if (take) begin
          state_next.done = 1'b1;
          case (req.op)
            OP_ROT_RIGHT: begin
              state_next.work = {state_reg.fl.c, req.mem[7:1]};
              state_next.fl.c = req.mem[0];
            end
            OP_SUBB_MEM, OP_SUBB_IMM, OP_SUBB_TO_MEM: begin
              if (req.op != OP_SUBB_TO_MEM) begin
                state_next.work = diff[7:0];
              end else begin
                state_next.mem_we = 1'b1;
                state_next.mem_wdata = diff[7:0];
              end
              state_next.fl.c = ~diff[8];
              state_next.fl.z = (diff[7:0] == RSS_ZERO);
              state_next.fl.range_exc = ovf;
              state_next.fl.nib_ok = ~ndiff[RSS_NIB];
              state_next.fl.sgn_brw = diff[7] ^ ovf;
              // chain only survives while every byte is zero
              state_next.fl.chain_z = (diff[7:0] == RSS_ZERO) &&
                state_reg.fl.chain_z;
            end
            OP_DEC_SKIP, OP_DEC_WORK: begin
              if (req.op == OP_DEC_SKIP) begin
                state_next.mem_we = 1'b1;
                state_next.mem_wdata = dec;
              end else begin
                state_next.work = dec;
              end
              if (dec == RSS_ZERO) begin
                state_next.skip = 1'b1;
                state_next.st = ST_DUMMY;
              end
            end
            OP_LOAD: begin
              // preload of working, link and chain start
              state_next.work = req.lit;
              state_next.fl.c = req.mem[0];
              state_next.fl.chain_z = req.mem[1];
            end
            default: begin
              state_next.done = 1'b1;
            end
          endcase
        end
      end
      ST_DUMMY: begin
        state_next.st = ST_RUN;
      end
      default: begin
        state_next.st = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= '{st: ST_RUN, work: RSS_WORK_RST, fl: RSS_FLAGS_RST,
        mem_we: 1'b0, mem_wdata: RSS_ZERO, skip: 1'b0, done: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign mem_we = state_reg.mem_we;
  assign mem_wdata = state_reg.mem_wdata;
  assign work = state_reg.work;
  assign flags = state_reg.fl;
  assign skip = state_reg.skip;
  assign done = state_reg.done;

  ////////////////////////////////////////////////////////////////////////
  // checks

  a_rot_result: assert property (
    @(posedge clk) disable iff (!nrst)
    (take && req.op == OP_ROT_RIGHT) |=>
      (work == {$past(flags.c), $past(req.mem[7:1])}) &&
      (flags.c == $past(req.mem[0])))
    else $error("rotate result or link wrong");

  a_rot_nowrite: assert property (
    @(posedge clk) disable iff (!nrst)
    (take && req.op == OP_ROT_RIGHT) |=>
      !mem_we && !skip && (flags.z == $past(flags.z)) &&
      (flags.range_exc == $past(flags.range_exc)) &&
      (flags.chain_z == $past(flags.chain_z)))
    else $error("rotate touched memory or other flags");

  a_rot_flags: assert property (
    @(posedge clk) disable iff (!nrst)
    (take && req.op == OP_ROT_RIGHT) |=>
      ({flags[5:3], flags[1:0]} == $past({flags[5:3], flags[1:0]})))
    else $error("rotate changed a flag other than link");

  a_subb_mem: assert property (
    @(posedge clk) disable iff (!nrst)
    (take && req.op == OP_SUBB_MEM) |=>
      work == 8'($past(work) - $past(req.mem) - 8'(!$past(flags.c))) &&
      !mem_we)
    else $error("memory subtract result wrong");

  a_subb_imm: assert property (
    @(posedge clk) disable iff (!nrst)
    (take && req.op == OP_SUBB_IMM) |=>
      work == 8'($past(work) - $past(req.lit) - 8'(!$past(flags.c))))
    else $error("immediate subtract result wrong");

  a_subb_tomem: assert property (
    @(posedge clk) disable iff (!nrst)
    (take && req.op == OP_SUBB_TO_MEM) |=>
      mem_we && (work == $past(work)) && (mem_wdata ==
      8'($past(work) - $past(req.mem) - 8'(!$past(flags.c)))))
    else $error("subtract to memory wrong");

  a_mem_link: assert property (
    @(posedge clk) disable iff (!nrst)
    (take && (req.op == OP_SUBB_MEM || req.op == OP_SUBB_TO_MEM)) |=>
      flags.c == ({1'b0, $past(work)} >=
      ({1'b0, $past(req.mem)} + 9'(!$past(flags.c)))))
    else $error("link after subtract wrong");

  a_imm_link: assert property (
    @(posedge clk) disable iff (!nrst)
    (take && req.op == OP_SUBB_IMM) |=>
      flags.c == ({1'b0, $past(work)} >=
      ({1'b0, $past(req.lit)} + 9'(!$past(flags.c)))))
    else $error("link after immediate subtract wrong");

  a_zero_sign: assert property (
    @(posedge clk) disable iff (!nrst)
    (take && req.op == OP_SUBB_MEM) |=>
      (flags.z == (work == RSS_ZERO)) &&
      (flags.sgn_brw == (work[7] ^ flags.range_exc)))
    else $error("subtract zero or signed flag wrong");

  a_tomem_zero: assert property (
    @(posedge clk) disable iff (!nrst)
    (take && req.op == OP_SUBB_TO_MEM) |=>
      (flags.z == (mem_wdata == RSS_ZERO)) &&
      (flags.sgn_brw == (mem_wdata[7] ^ flags.range_exc)))
    else $error("subtract to memory flags wrong");

  a_nibble_flag: assert property (
    @(posedge clk) disable iff (!nrst)
    (take && is_borrow_op(req.op)) |=>
      flags.nib_ok == ({1'b0, $past(work[3:0])} >=
      ({1'b0, $past(sub_b[3:0])} + 5'(!$past(flags.c)))))
    else $error("nibble borrow flag wrong");

  a_chain_flag: assert property (
    @(posedge clk) disable iff (!nrst)
    (take && is_borrow_op(req.op)) |=>
      flags.chain_z == (flags.z && $past(flags.chain_z)))
    else $error("chained zero flag wrong");

  a_dec_skip: assert property (
    @(posedge clk) disable iff (!nrst)
    (take && req.op == OP_DEC_SKIP && req.mem == RSS_ONE) |=>
      (skip && mem_we && mem_wdata == RSS_ZERO && !req_ready) ##1
      (req_ready && !skip))
    else $error("zero decrement did not skip for one cycle");

  // one dead cycle only, so the sequencer never stalls twice
  a_dummy_single: assert property (
    @(posedge clk) disable iff (!nrst)
    skip |-> !req_ready ##1 (req_ready && !done))
    else $error("dummy cycle not exactly one cycle");

  a_dec_noskip: assert property (
    @(posedge clk) disable iff (!nrst)
    (take && (req.op == OP_DEC_SKIP || req.op == OP_DEC_WORK) &&
      req.mem != RSS_ONE) |=> !skip && req_ready)
    else $error("non-zero decrement skipped");

  a_stray_skip: assert property (
    @(posedge clk) disable iff (!nrst)
    !(take && (req.op == OP_DEC_SKIP || req.op == OP_DEC_WORK)) |=>
      !skip)
    else $error("skip without a decrement");

  a_dec_work: assert property (
    @(posedge clk) disable iff (!nrst)
    (take && req.op == OP_DEC_WORK) |=>
      !mem_we && (work == 8'($past(req.mem) - RSS_ONE)) &&
      (skip == (work == RSS_ZERO)))
    else $error("decrement to working wrong");

  a_dec_wrap: assert property (
    @(posedge clk) disable iff (!nrst)
    (take && req.op == OP_DEC_WORK && req.mem == RSS_ZERO) |=>
      (work == 8'hff) && !skip)
    else $error("decrement did not wrap");

  a_dec_flags: assert property (
    @(posedge clk) disable iff (!nrst)
    (take && (req.op == OP_DEC_SKIP || req.op == OP_DEC_WORK)) |=>
      flags == $past(flags))
    else $error("decrement changed a flag");

  a_dec_write: assert property (
    @(posedge clk) disable iff (!nrst)
    (take && req.op == OP_DEC_SKIP) |=>
      mem_we && (mem_wdata == 8'($past(req.mem) - RSS_ONE)) &&
      (work == $past(work)))
    else $error("decrement write-back wrong");

  // a stray write would corrupt a location the sequencer never named
  a_stray_write: assert property (
    @(posedge clk) disable iff (!nrst)
    !(take && (req.op == OP_SUBB_TO_MEM || req.op == OP_DEC_SKIP)) |=>
      !mem_we)
    else $error("memory written by a non-writing instruction");

endmodule

//--- design/rss_pkg.sv
/*
  rss_pkg: shared types and constants for the rotate, borrow-subtract
  and decrement-skip execution datapath.
  assumes one core clock and an 8-bit data memory outside the block.
*/
package rss_pkg;

  localparam int RSS_W = 8;
  localparam logic [7:0] RSS_WORK_RST = 8'h00;
  localparam logic [7:0] RSS_ONE = 8'h01;
  localparam logic [7:0] RSS_ZERO = 8'h00;
  localparam int RSS_NIB = 4;

  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_ROT_RIGHT = 3'h1,
    OP_SUBB_MEM = 3'h2,
    OP_SUBB_IMM = 3'h3,
    OP_SUBB_TO_MEM = 3'h4,
    OP_DEC_SKIP = 3'h5,
    OP_DEC_WORK = 3'h6,
    OP_LOAD = 3'h7
  } rss_op_e;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_DUMMY = 2'b10
  } rss_state_e;

  typedef struct packed {
    logic range_exc;
    logic z;
    logic nib_ok;
    logic c;
    logic sgn_brw;
    logic chain_z;
  } rss_flags_s;

  localparam rss_flags_s RSS_FLAGS_RST = '0;

  typedef struct packed {
    logic valid;
    rss_op_e op;
    logic [7:0] mem;
    logic [7:0] lit;
  } rss_req_s;

  typedef struct packed {
    rss_state_e st;
    logic [7:0] work;
    rss_flags_s fl;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic skip;
    logic done;
  } rss_core_s;

endpackage

//--- dv/rotate_subtract_skip_exec_tb.sv
/*
  rotate_subtract_skip_exec_tb: directed tests of the execution datapath.
  assumes the bench plays the sequencer and forwards operands itself.
*/
`timescale 1ns/1ps
module rotate_subtract_skip_exec_tb;
  import rss_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  rss_req_s req = '0;
  logic req_ready, mem_we, skip, done;
  logic [7:0] mem_wdata, work, mm_rdata;
  rss_flags_s flags, f;
  logic [1:0] mm_addr = 2'h0;
  int fails = 0;
  int compares = 0;

  rss_exec dut_u (.clk(clk), .nrst(nrst), .req(req),
    .req_ready(req_ready), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .work(work), .flags(flags), .skip(skip), .done(done));
  rss_mem_model mm_u (.clk(clk), .we(mem_we), .wdata(mem_wdata),
    .addr(mm_addr), .rdata(mm_rdata));

  initial forever #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // one instruction, outputs sampled just after the answer edge
  task automatic exec(input rss_op_e op, input logic [7:0] m, l);
    @(posedge clk);
    req <= '{1'b1, op, m, l};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_rot();
    exec(OP_LOAD, 8'h01, 8'h33);
    f = flags;
    exec(OP_ROT_RIGHT, 8'h5a, 8'h00);
    chk(work, 8'had);
    chk(flags.c, 1'b0);
    chk({mem_we, done}, 2'b01);
    chk({flags[5:3], flags[1:0]}, {f[5:3], f[1:0]});
    exec(OP_ROT_RIGHT, 8'h01, 8'h00);
    chk({work, 7'h00, flags.c}, {8'h00, 8'h01});
    $display("rotate test done");
  endtask

  task automatic t_sbc();
    logic [7:0] wv [4] = '{8'h10, 8'h05, 8'h05, 8'h80};
    logic [7:0] mv [4] = '{8'h05, 8'h05, 8'h05, 8'h01};
    logic cv [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    logic [8:0] d;
    logic [4:0] n;
    logic ov;
    int k;
    for (int i = 0; i < 8; i++) begin
      k = i % 4;
      exec(OP_LOAD, {7'h00, cv[k]}, wv[k]);
      d = {1'b0, wv[k]} - {1'b0, mv[k]} - 9'(!cv[k]);
      n = {1'b0, wv[k][3:0]} - {1'b0, mv[k][3:0]} - 5'(!cv[k]);
      ov = (wv[k][7] != mv[k][7]) && (d[7] != wv[k][7]);
      exec(i < 4 ? OP_SUBB_MEM : OP_SUBB_IMM, i < 4 ? mv[k] : ~mv[k],
        i < 4 ? ~mv[k] : mv[k]);
      chk(work, d[7:0]);
      chk(flags.c, !d[8]);
      chk({flags.range_exc, flags.z, flags.nib_ok, flags.sgn_brw},
        {ov, d[7:0] == 8'h00, !n[4], d[7] ^ ov});
    end
    $display("subtract test done");
  endtask

  task automatic t_subtract_borrow_to_memory();
    exec(OP_LOAD, 8'h01, 8'h20);
    exec(OP_SUBB_TO_MEM, 8'h30, 8'h00);
    chk({work, mem_wdata}, {8'h20, 8'hf0});
    chk({mem_we, flags.c}, 2'b10);
    @(posedge clk);
    #1;
    chk(mm_rdata, 8'hf0);
    exec(OP_LOAD, 8'h03, 8'h30);
    exec(OP_SUBB_TO_MEM, 8'h30, 8'h00);
    chk({mem_wdata, 5'h00, flags.z, flags.c, flags.chain_z}, 16'h0007);
    $display("subtract to memory test done");
  endtask

  task automatic t_skip();
    f = flags;
    @(posedge clk);
    req <= '{1'b1, OP_DEC_SKIP, 8'h01, 8'h00};
    @(posedge clk);
    req <= '{1'b1, OP_SUBB_IMM, 8'h00, 8'h00};
    #1;
    chk({mem_we, skip, done, req_ready}, 4'b1110);
    chk(mem_wdata, 8'h00);
    @(posedge clk);
    #1;
    chk({done, req_ready, skip}, 3'b010);
    chk({mm_rdata, 2'h0, flags}, {8'h00, 2'h0, f});
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    chk(done, 1'b1);
    exec(OP_DEC_SKIP, 8'h00, 8'h00);
    chk({mem_we, skip, req_ready}, 3'b101);
    chk(mem_wdata, 8'hff);
    exec(OP_DEC_WORK, 8'h01, 8'h00);
    chk({work, 6'h00, mem_we, skip}, {8'h00, 8'h01});
    exec(OP_DEC_WORK, 8'h10, 8'h00);
    chk({work, 6'h00, mem_we, skip}, {8'h0f, 8'h00});
    $display("decrement skip test done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    chk({req_ready, mem_we, skip, done, work}, {4'b1000, 8'h00});
    nrst <= 1'b1;
    t_rot();
    t_sbc();
    t_subtract_borrow_to_memory();
    t_skip();
    tally_and_finish();
  end

  // all tests need well under 100 cycles of 5 ns
  initial begin
    #20000;
    fails++;
    tally_and_finish();
  end
endmodule

//--- dv/rss_mem_model.sv
/*
  rss_mem_model: small data memory standing behind the datapath.
  assumes writes arrive as one-cycle mem_we pulses on clk.
*/
`timescale 1ns/1ps
module rss_mem_model (
  // clock
  input wire logic clk,
  // write side
  input wire logic we,
  input wire logic [7:0] wdata,
  // read side
  input wire logic [1:0] addr,
  output logic [7:0] rdata
);
  logic [7:0] mem_reg [4];
  ////////////////////////////////////////////////////////////////////////
  // store write-back
  always_ff @(posedge clk) begin
    if (we) begin
      mem_reg[addr] <= wdata;
    end
  end
  // read is combinational, so it shows a write one edge later
  assign rdata = mem_reg[addr];
endmodule
